// ### dv/sdram_link_chk.sv
// Concurrent checks on the SDRAM command link
`timescale 1ns/1ps
`default_nettype none
module sdram_link_chk
   import sdram_cmd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [BYTES-1:0] dqm,
   input wire logic dq_c_oe,
   input wire logic [BYTES-1:0] dq_d_oe
);
   wire logic [3:0] stb = {cs_n, ras_n, cas_n, we_n};
   wire logic is_nop = cs_n || (stb == 4'h7);
   wire logic rd_cmd = (stb == 4'h5) && cke;
   wire logic wr_cmd = (stb == 4'h4) && cke;
   wire logic any_oe = |dq_d_oe;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Drive seen at an edge was set one edge earlier from a mask two edges older
   property p_mask_hiz;
      any_oe |-> (dq_d_oe & $past(dqm, 3)) == 4'h0;
   endproperty
   property p_rd_lat;
      $rose(any_oe) |-> $past(rd_cmd, 3);
   endproperty
   property p_cke_fall;
      $fell(cke) |-> stb == 4'h1;
   endproperty
   property p_mode_gap;
      (stb == 4'h0) && cke |=> is_nop;
   endproperty
   property p_one_shot;
      !is_nop |=> is_nop;
   endproperty
   property p_wr_drive;
      wr_cmd |-> dq_c_oe;
   endproperty
   property p_oe_cause;
      $rose(dq_c_oe) |-> wr_cmd;
   endproperty
   property p_stop_quiet;
      stb == 4'h6 |-> !dq_c_oe;
   endproperty
   a_mask_hiz: assert property (p_mask_hiz) else $error("read byte driven under mask");
   a_rd_lat: assert property (p_rd_lat) else $error("read data late or early");
   a_cke_fall: assert property (p_cke_fall) else $error("clock enable fell off refresh");
   a_mode_gap: assert property (p_mode_gap) else $error("command right after mode load");
   a_one_shot: assert property (p_one_shot) else $error("command held over two cycles");
   a_wr_drive: assert property (p_wr_drive) else $error("write without data drive");
   a_oe_cause: assert property (p_oe_cause) else $error("data drive without write");
   a_stop_quiet: assert property (p_stop_quiet) else $error("stop during write drive");
   c_read: cover property (rd_cmd);
   c_mode: cover property (stb == 4'h0);
   c_self: cover property ($fell(cke));
endmodule : sdram_link_chk
`default_nettype wire

// ### dv/tb.sv
// Testbench: APB stimulus, memory model and checks across both link ends
`timescale 1ns/1ps
`default_nettype none
module tb
   import sdram_cmd_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, r, wd;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, mem_rd, mem_wr, refresh_stb, self_refresh;
   wire logic [1:0] mem_bank;
   wire logic [ROW_W-1:0] mem_row, refresh_row;
   wire logic [COL_W-1:0] mem_col;
   wire logic [DATA_W-1:0] mem_wdata;
   wire logic [BYTES-1:0] mem_byte_en, bank_open;
   wire logic [ADDR_W-1:0] mode_reg;
   logic [DATA_W-1:0] mem_rdata = 32'h0;
   logic [DATA_W-1:0] ram [logic [20:0]];
   logic [56:0] wq [$];
   logic [3:0] exp_open = 4'h0, m1, m2;
   logic [10:0] rows [4];
   logic [7:0] col;
   int bad_count = 0, samples_checked = 0, nref = 0;
   sdram_link_if lk (.pclk(pclk));
   sdram_ctrl_end u_sdram_ctrl_end (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(lk));
   sdram_dev_end u_sdram_dev_end (.pclk(pclk), .presetn(presetn), .link(lk), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
      .mem_wdata(mem_wdata), .mem_byte_en(mem_byte_en), .mem_rdata(mem_rdata),
      .refresh_stb(refresh_stb), .refresh_row(refresh_row), .self_refresh(self_refresh),
      .bank_open(bank_open), .mode_reg(mode_reg));
   sdram_link_chk chk_i (.pclk(pclk), .presetn(presetn), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
      .cas_n(lk.cas_n), .we_n(lk.we_n), .cke(lk.cke), .dqm(lk.dqm), .dq_c_oe(lk.dq_c_oe),
      .dq_d_oe(lk.dq_d_oe));
   initial
   begin
      forever #25 pclk = ~pclk;
   end
   function automatic logic [31:0] bm(input logic [3:0] m);
      for (int i = 0; i < 4; i++) bm[8*i +: 8] = {8{m[i]}};
   endfunction : bm
   function automatic logic [31:0] rd(input logic [20:0] k);
      return ram.exists(k) ? ram[k] : 32'h0;
   endfunction : rd
   // Synchronous memory behind the device end, plus write beat log
   always @(posedge pclk)
   begin
      if (mem_wr === 1'b1)
      begin
         wq.push_back({mem_bank, mem_row, mem_col, mem_byte_en, mem_wdata});
         ram[{mem_bank, mem_row, mem_col}] = (rd({mem_bank, mem_row, mem_col}) &
            ~bm(mem_byte_en)) | (mem_wdata & bm(mem_byte_en));
      end
      if (mem_rd === 1'b1) mem_rdata <= rd({mem_bank, mem_row, mem_col});
      if (refresh_stb === 1'b1) nref++;
   end
   task chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready, read data and error are all taken at one rising edge
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 100);
      if (pready !== 1'b1)
      begin
         bad_count++;
         $display("ERROR %0t: no ready", $time);
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task idle;
      int n;
      n = 0;
      do apb(1'b0, STATUS_OFS, 32'h0); while (r[ST_BUSY] !== 1'b0 && ++n < 20);
      if (r[ST_BUSY] !== 1'b0)
      begin
         bad_count++;
         $display("ERROR %0t: stays busy", $time);
      end
   endtask : idle
   task cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      apb(1'b1, CMD_OFS, {12'h000, a, 2'b00, b, c});
      idle;
      // Last beat is logged at the edge the poll ends on
      @(posedge pclk);
   endtask : cmd
   task close_out;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      $display("ERROR %0t: timeout", $time);
      close_out;
   end
   initial
   begin
      void'($urandom(32'hd28a18d6));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(mode_reg, MODE_RESET);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      cmd(4'h9, 2'h0, 12'h001);
      chk(mode_reg, 12'h001);
      $display("test mode done");
      for (int b = 0; b < 4; b++)
      begin
         rows[b] = 11'($urandom);
         cmd(4'h2, 2'(b), {1'b0, rows[b]});
         exp_open[b] = 1'b1;
         chk(bank_open, exp_open);
      end
      cmd(4'h2, 2'h0, 12'h000);
      chk(r[ST_REFUSED], 1'b1);
      apb(1'b1, STATUS_OFS, 32'h2);
      $display("test activate done");
      for (int b = 0; b < 4; b++)
      begin
         wd = $urandom;
         m1 = 4'($urandom);
         m2 = 4'($urandom % 15);
         col = 8'($urandom);
         apb(1'b1, WDATA_OFS, wd);
         apb(1'b1, MASK_OFS, {28'h0, m1});
         cmd(4'h4, 2'(b), {4'h0, col});
         chk(wq.size(), 2);
         chk(wq.pop_front(), {2'(b), rows[b], col, ~m1, wd});
         chk(wq.pop_front(), {2'(b), rows[b], col[7:1], ~col[0], ~m1, wd});
         apb(1'b1, MASK_OFS, {28'h0, m2});
         cmd(4'h3, 2'(b), {1'b0, b == 3, 2'b00, col});
         idle;
         apb(1'b0, RDATA_OFS, 32'h0);
         chk(r, wd & ~bm(m1) & ~bm(m2));
      end
      exp_open[3] = 1'b0;
      chk(bank_open, exp_open);
      $display("test burst done");
      cmd(4'h5, 2'h0, 12'h000);
      chk(bank_open, exp_open);
      cmd(4'h6, 2'h0, 12'h000);
      exp_open[0] = 1'b0;
      chk(bank_open, exp_open);
      for (int c = 0; c < 2; c++)
      begin
         cmd(4'(c), 2'h1, 12'h400);
         chk(bank_open, exp_open);
      end
      cmd(4'h6, 2'h0, 12'h400);
      chk(bank_open, 4'h0);
      apb(1'b1, CMD_OFS, 32'h0000000a);
      idle;
      chk(r[ST_REFUSED], 1'b1);
      $display("test precharge done");
      cmd(4'h7, 2'h0, 12'h000);
      chk(nref, 1);
      chk(refresh_row, 11'(nref));
      cmd(4'h8, 2'h0, 12'h000);
      chk({self_refresh, lk.cke}, 2'b10);
      cmd(4'h1, 2'h0, 12'h000);
      chk(self_refresh, 1'b0);
      $display("test refresh done");
      close_out;
   end
endmodule : tb
`default_nettype wire

// ### hw/cmd_decode.sv
// Strobe-to-command decoder of the SDRAM end
`timescale 1ns/1ps
`default_nettype none
module cmd_decode
   import sdram_cmd_pkg::*;
(
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   output var cmd_e cmd
);
   always_comb
   begin
      cmd = cmd_reserved;
      if (cs_n)
         cmd = cmd_inhibit;
      else if (!cke)
         // Only self refresh entry is legal with the clock enable low
         cmd = ({ras_n, cas_n, we_n} == 3'h1) ? cmd_self_refresh : cmd_reserved;
      else
      begin
         case ({ras_n, cas_n, we_n})
            3'h7: cmd = cmd_nop;
            3'h3: cmd = cmd_active;
            3'h5: cmd = cmd_read;
            3'h4: cmd = cmd_write;
            3'h6: cmd = cmd_burst_stop;
            3'h2: cmd = cmd_precharge;
            3'h1: cmd = cmd_refresh;
            3'h0: cmd = mode_load_cmd;
            default: cmd = cmd_reserved;
         endcase
      end
   end
endmodule : cmd_decode
`default_nettype wire

// ### hw/sdram_cmd_pkg.sv
// Shared constants, command type and helpers for the SDRAM command link
package sdram_cmd_pkg;

   typedef enum logic [3:0] {
      cmd_inhibit,
      cmd_nop,
      cmd_active,
      cmd_read,
      cmd_write,
      cmd_burst_stop,
      cmd_precharge,
      cmd_refresh,
      cmd_self_refresh,
      mode_load_cmd,
      cmd_reserved
   } cmd_e;

   localparam int ROW_W = 11;
   localparam int COL_W = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int BYTES = 4;
   localparam int BANKS = 4;
   localparam int AP_BIT = 10;
   localparam int BL_LSB = 0;
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;

   localparam int CLK_PERIOD_NS = 50;
   localparam int ROW_PRECHARGE_TIME_NS = 20;
   localparam int ROW_PRECHARGE_CK = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE_SET_TIME_CK = 2;
   localparam int READ_LATENCY_CK = 2;
   localparam logic [5:0] SELF_REF_LAST = 6'h3f;

   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] WDATA_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] RDATA_OFS = 8'h10;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_SELF_REF = 2;
   localparam int ST_OPEN_LSB = 4;

   // Strobe pattern {select, row, column, write}, all active low
   function automatic logic [3:0] cmd_strobes(input cmd_e c);
      case (c)
         cmd_inhibit: return 4'hf;
         cmd_active: return 4'h3;
         cmd_read: return 4'h5;
         cmd_write: return 4'h4;
         cmd_burst_stop: return 4'h6;
         cmd_precharge: return 4'h2;
         cmd_refresh: return 4'h1;
         cmd_self_refresh: return 4'h1;
         mode_load_cmd: return 4'h0;
         default: return 4'h7;
      endcase
   endfunction : cmd_strobes

   // Unlisted codes fall back to single beats
   function automatic logic [8:0] burst_len(input logic [2:0] code);
      case (code)
         3'h1: return 9'h002;
         3'h2: return 9'h004;
         3'h3: return 9'h008;
         3'h7: return 9'h100;
         default: return 9'h001;
      endcase
   endfunction : burst_len

   // Column advance wraps inside the burst-aligned block
   function automatic logic [COL_W-1:0] col_next(input logic [COL_W-1:0] col,
                                                 input logic [8:0] len);
      logic [COL_W-1:0] mask;
      logic [COL_W-1:0] inc;
      mask = 8'(len - 9'h001);
      inc = col + 8'h01;
      return (col & ~mask) | (inc & mask);
   endfunction : col_next

endpackage : sdram_cmd_pkg

// ### hw/sdram_ctrl_end.sv
// Controller end: APB-programmed command issue onto the SDRAM link
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_end
   import sdram_cmd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sdram_link_if.ctrl link
);
   cmd_e req;
   logic [1:0] rbank;
   logic [ADDR_W-1:0] raddr;
   logic wr_en;
   logic cmd_wr;
   logic busy;
   logic legal;
   logic issue;
   logic wake;
   logic refuse;
   logic clr_refused;
   logic mapped;
   logic [31:0] rd_mux;

   logic [3:0] strobes_r;
   logic [1:0] bank_r;
   logic [ADDR_W-1:0] addr_r;
   logic cke_r;
   logic [1:0] wait_r;
   logic [8:0] wbeats_r;
   logic [2:0] bl_code_r;
   logic [BANKS-1:0] open_r;
   logic [DATA_W-1:0] wdata_r;
   logic [BYTES-1:0] mask_r;
   logic [DATA_W-1:0] rdata_r;
   logic refused_r;
   logic dq_oe_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   assign wr_en = psel && penable && pready_r && pwrite;
   assign cmd_wr = wr_en && (paddr == CMD_OFS);
   assign req = cmd_e'(pwdata[CMD_CODE_LSB +: 4]);
   assign rbank = pwdata[CMD_BANK_LSB +: 2];
   assign raddr = pwdata[CMD_ADDR_LSB +: ADDR_W];
   assign busy = (wait_r != 2'h0) || (wbeats_r != 9'h000);
   assign wake = cmd_wr && !cke_r;
   assign issue = cmd_wr && cke_r && !busy && legal;
   assign refuse = cmd_wr && cke_r && !issue;
   assign clr_refused = wr_en && (paddr == STATUS_OFS) && pwdata[ST_REFUSED];
   assign mapped = (paddr == CMD_OFS) || (paddr == WDATA_OFS) || (paddr == MASK_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == RDATA_OFS);

   always_comb
   begin
      case (req)
         cmd_active: legal = !open_r[rbank];
         cmd_read, cmd_write: legal = open_r[rbank];
         cmd_refresh, cmd_self_refresh, mode_load_cmd: legal = (open_r == '0);
         cmd_nop, cmd_inhibit, cmd_burst_stop, cmd_precharge: legal = 1'h1;
         default: legal = 1'h0;
      endcase
   end

   always_comb
   begin
      case (paddr)
         WDATA_OFS: rd_mux = wdata_r;
         MASK_OFS: rd_mux = {28'h0000000, mask_r};
         STATUS_OFS: rd_mux = {24'h000000, open_r, 1'h0, !cke_r, refused_r, busy};
         RDATA_OFS: rd_mux = rdata_r;
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Zero-wait slave: ready rises in the access cycle itself
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'h0;
         pslverr_r <= 1'h0;
         prdata_r <= '0;
         wdata_r <= '0;
         mask_r <= '0;
         refused_r <= 1'h0;
      end
      else
      begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !mapped;
         prdata_r <= rd_mux;
         if (wr_en && (paddr == WDATA_OFS))
            wdata_r <= pwdata;
         if (wr_en && (paddr == MASK_OFS))
            mask_r <= pwdata[BYTES-1:0];
         // A refusal in the clearing cycle is kept
         if (refuse)
            refused_r <= 1'h1;
         else if (clr_refused)
            refused_r <= 1'h0;
      end
   end

   // Link side: one command cycle per accepted order, no-ops between
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strobes_r <= cmd_strobes(cmd_inhibit);
         bank_r <= '0;
         addr_r <= '0;
         cke_r <= 1'h1;
         wait_r <= '0;
         wbeats_r <= '0;
         bl_code_r <= '0;
         open_r <= '0;
         dq_oe_r <= 1'h0;
         rdata_r <= '0;
      end
      else
      begin
         strobes_r <= issue ? cmd_strobes(req) : cmd_strobes(cmd_nop);
         if (issue)
         begin
            bank_r <= rbank;
            addr_r <= raddr;
         end
         if (issue && (req == cmd_self_refresh))
            cke_r <= 1'h0;
         else if (wake)
            cke_r <= 1'h1;
         if (issue && (req == cmd_precharge))
            wait_r <= 2'(ROW_PRECHARGE_CK);
         else if (issue && (req == mode_load_cmd))
            wait_r <= 2'(MODE_SET_TIME_CK);
         else if (wake)
            wait_r <= 2'h1;
         else if (wait_r != 2'h0)
            wait_r <= wait_r - 2'h1;
         if (issue && (req == cmd_write))
            wbeats_r <= burst_len(bl_code_r) - 9'h001;
         else if (wbeats_r != 9'h000)
            wbeats_r <= wbeats_r - 9'h001;
         // Drive lasts through the cycle of the last beat, which is sampled one edge later
         dq_oe_r <= (issue && (req == cmd_write)) || (wbeats_r != 9'h000);
         if (issue && (req == mode_load_cmd))
            bl_code_r <= raddr[BL_LSB +: 3];
         if (issue && (req == cmd_active))
            open_r[rbank] <= 1'h1;
         else if (issue && (req == cmd_precharge) && raddr[AP_BIT])
            open_r <= '0;
         else if (issue && ((req == cmd_precharge) || (((req == cmd_read) ||
                  (req == cmd_write)) && raddr[AP_BIT])))
            open_r[rbank] <= 1'h0;
         if (link.dq_d_oe != '0)
            rdata_r <= link.dq;
      end
   end

   assign link.cs_n = strobes_r[3];
   assign link.ras_n = strobes_r[2];
   assign link.cas_n = strobes_r[1];
   assign link.we_n = strobes_r[0];
   assign link.cke = cke_r;
   assign link.bank_select_lo = bank_r[0];
   assign link.bank_select_hi = bank_r[1];
   assign link.addr = addr_r;
   assign link.dqm = mask_r;
   assign link.dq_c2d = wdata_r;
   assign link.dq_c_oe = dq_oe_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
endmodule : sdram_ctrl_end
`default_nettype wire

// ### hw/sdram_dev_end.sv
// SDRAM end: command execution, bank rows, bursts, masks and refresh
`timescale 1ns/1ps
`default_nettype none
module sdram_dev_end
   import sdram_cmd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   sdram_link_if.dev link,
   output logic mem_rd,
   output logic mem_wr,
   output logic [1:0] mem_bank,
   output logic [ROW_W-1:0] mem_row,
   output logic [COL_W-1:0] mem_col,
   output logic [DATA_W-1:0] mem_wdata,
   output logic [BYTES-1:0] mem_byte_en,
   input wire logic [DATA_W-1:0] mem_rdata,
   output logic refresh_stb,
   output logic [ROW_W-1:0] refresh_row,
   output logic self_refresh,
   output logic [BANKS-1:0] bank_open,
   output logic [ADDR_W-1:0] mode_reg
);
   cmd_e cmd;
   logic [1:0] bank;
   logic ap;
   logic awake;
   logic all_idle;
   logic acc_act;
   logic acc_rd;
   logic acc_wr;
   logic acc_pre;
   logic acc_bst;
   logic acc_ref;
   logic acc_sref;
   logic acc_mode;
   logic pre_hits;
   logic stop;
   logic new_burst;
   logic cont;
   logic beat;
   logic beat_wr;
   logic beat_ap;
   logic last_beat;
   logic ap_close;
   logic stop_close;
   logic sr_tick;
   logic [1:0] beat_bank;
   logic [COL_W-1:0] beat_col;
   logic [8:0] beat_len;
   logic [8:0] new_len;
   logic [BANKS-1:0] row_open_nxt;

   logic [BANKS-1:0] row_open_r;
   logic [ROW_W-1:0] open_row_r [BANKS];
   logic [ADDR_W-1:0] mode_r;
   logic bst_act_r;
   logic bst_wr_r;
   logic bst_ap_r;
   logic [1:0] bst_bank_r;
   logic [COL_W-1:0] bst_col_r;
   logic [8:0] bst_len_r;
   logic [8:0] bst_left_r;
   logic mem_rd_r;
   logic mem_wr_r;
   logic [1:0] mem_bank_r;
   logic [ROW_W-1:0] mem_row_r;
   logic [COL_W-1:0] mem_col_r;
   logic [DATA_W-1:0] mem_wdata_r;
   logic [BYTES-1:0] mem_be_r;
   logic rd_v1_r;
   logic rd_v2_r;
   logic [BYTES-1:0] dqm_p1_r;
   logic [BYTES-1:0] dqm_p2_r;
   logic [BYTES-1:0] dq_oe_r;
   logic [DATA_W-1:0] dq_out_r;
   logic self_ref_r;
   logic [5:0] sr_cnt_r;
   logic refresh_stb_r;
   logic [ROW_W-1:0] refresh_row_r;

   // Every link input is taken at the rising edge below
   cmd_decode u_dec (
      .cs_n(link.cs_n),
      .ras_n(link.ras_n),
      .cas_n(link.cas_n),
      .we_n(link.we_n),
      .cke(link.cke),
      .cmd(cmd)
   );

   assign bank = {link.bank_select_hi, link.bank_select_lo};
   assign ap = link.addr[AP_BIT];
   // While in self refresh only the clock enable is looked at
   assign awake = !self_ref_r;
   assign all_idle = (row_open_r == '0);
   assign new_len = burst_len(mode_r[BL_LSB +: 3]);

   // Activate to an open bank is dropped: that row must be closed first
   assign acc_act = awake && (cmd == cmd_active) && !row_open_r[bank];
   assign acc_rd = awake && (cmd == cmd_read) && row_open_r[bank];
   assign acc_wr = awake && (cmd == cmd_write) && row_open_r[bank];
   assign acc_pre = awake && (cmd == cmd_precharge);
   assign acc_bst = awake && (cmd == cmd_burst_stop);
   assign acc_ref = awake && (cmd == cmd_refresh) && all_idle;
   assign acc_sref = awake && (cmd == cmd_self_refresh) && all_idle;
   assign acc_mode = awake && (cmd == mode_load_cmd) && all_idle;

   // Precharge of the bursting bank also cuts the burst short
   assign pre_hits = acc_pre && (ap || (bank == bst_bank_r));
   assign stop = acc_bst || pre_hits;
   assign new_burst = acc_rd || acc_wr;
   assign cont = bst_act_r && !new_burst && !stop;
   assign beat = new_burst || cont;
   assign beat_wr = new_burst ? acc_wr : bst_wr_r;
   assign beat_ap = new_burst ? ap : bst_ap_r;
   assign beat_bank = new_burst ? bank : bst_bank_r;
   assign beat_col = new_burst ? link.addr[COL_W-1:0] : bst_col_r;
   assign beat_len = new_burst ? new_len : bst_len_r;
   assign last_beat = new_burst ? (new_len == 9'h001) : (bst_left_r == 9'h001);
   assign ap_close = beat && last_beat && beat_ap;
   assign stop_close = acc_bst && bst_act_r && bst_ap_r;
   assign sr_tick = self_ref_r && (sr_cnt_r == SELF_REF_LAST);

   always_comb
   begin
      row_open_nxt = row_open_r;
      if (ap_close)
         row_open_nxt[beat_bank] = 1'h0;
      if (stop_close)
         row_open_nxt[bst_bank_r] = 1'h0;
      if (acc_pre && ap)
         row_open_nxt = '0;
      else if (acc_pre)
         row_open_nxt[bank] = 1'h0;
      if (acc_act)
         row_open_nxt[bank] = 1'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         row_open_r <= '0;
         mode_r <= MODE_RESET;
         for (int i = 0; i < BANKS; i++)
            open_row_r[i] <= '0;
      end
      else
      begin
         row_open_r <= row_open_nxt;
         if (acc_act)
            open_row_r[bank] <= link.addr[ROW_W-1:0];
         if (acc_mode)
            mode_r <= link.addr;
      end
   end

   // Burst sequencer: one column beat per clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bst_act_r <= 1'h0;
         bst_wr_r <= 1'h0;
         bst_ap_r <= 1'h0;
         bst_bank_r <= '0;
         bst_col_r <= '0;
         bst_len_r <= 9'h001;
         bst_left_r <= '0;
      end
      else if (beat)
      begin
         bst_act_r <= !last_beat;
         bst_wr_r <= beat_wr;
         bst_ap_r <= beat_ap;
         bst_bank_r <= beat_bank;
         bst_len_r <= beat_len;
         bst_col_r <= col_next(beat_col, beat_len);
         bst_left_r <= (new_burst ? new_len : bst_left_r) - 9'h001;
      end
      else if (stop)
         bst_act_r <= 1'h0;
   end

   // Array port; a fully masked write beat still strobes with no enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_rd_r <= 1'h0;
         mem_wr_r <= 1'h0;
         mem_bank_r <= '0;
         mem_row_r <= '0;
         mem_col_r <= '0;
         mem_wdata_r <= '0;
         mem_be_r <= '0;
      end
      else
      begin
         mem_rd_r <= beat && !beat_wr;
         mem_wr_r <= beat && beat_wr;
         mem_bank_r <= beat_bank;
         mem_row_r <= open_row_r[beat_bank];
         mem_col_r <= beat_col;
         mem_wdata_r <= link.dq;
         mem_be_r <= ~link.dqm;
      end
   end

   // Read return lines up with the mask taken two edges earlier
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_v1_r <= 1'h0;
         rd_v2_r <= 1'h0;
         dqm_p1_r <= '1;
         dqm_p2_r <= '1;
         dq_oe_r <= '0;
         dq_out_r <= '0;
      end
      else
      begin
         rd_v1_r <= beat && !beat_wr;
         rd_v2_r <= rd_v1_r;
         dqm_p1_r <= link.dqm;
         dqm_p2_r <= dqm_p1_r;
         dq_oe_r <= {BYTES{rd_v2_r}} & ~dqm_p2_r;
         dq_out_r <= mem_rdata;
      end
   end

   // Refresh: external command or self-timed tick, row from own counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         self_ref_r <= 1'h0;
         sr_cnt_r <= '0;
         refresh_stb_r <= 1'h0;
         refresh_row_r <= '0;
      end
      else
      begin
         if (acc_sref)
            self_ref_r <= 1'h1;
         else if (self_ref_r && link.cke)
            self_ref_r <= 1'h0;
         sr_cnt_r <= self_ref_r ? sr_cnt_r + 6'h01 : 6'h00;
         refresh_stb_r <= acc_ref || sr_tick;
         if (acc_ref || sr_tick)
            refresh_row_r <= refresh_row_r + 11'h001;
      end
   end

   assign mem_rd = mem_rd_r;
   assign mem_wr = mem_wr_r;
   assign mem_bank = mem_bank_r;
   assign mem_row = mem_row_r;
   assign mem_col = mem_col_r;
   assign mem_wdata = mem_wdata_r;
   assign mem_byte_en = mem_be_r;
   assign refresh_stb = refresh_stb_r;
   assign refresh_row = refresh_row_r;
   assign self_refresh = self_ref_r;
   assign bank_open = row_open_r;
   assign mode_reg = mode_r;
   assign link.dq_d2c = dq_out_r;
   assign link.dq_d_oe = dq_oe_r;
endmodule : sdram_dev_end
`default_nettype wire

// ### hw/sdram_link_if.sv
// Command, address, mask and data link between controller and SDRAM
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if
   import sdram_cmd_pkg::*;
(
   input wire logic pclk
);
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic cke;
   logic bank_select_lo;
   logic bank_select_hi;
   logic [ADDR_W-1:0] addr;
   logic [BYTES-1:0] dqm;
   logic [DATA_W-1:0] dq_c2d;
   logic dq_c_oe;
   logic [DATA_W-1:0] dq_d2c;
   logic [BYTES-1:0] dq_d_oe;
   wire logic [DATA_W-1:0] dq;

   // Device byte drive wins; undriven bytes read as zero
   for (genvar i = 0; i < BYTES; i++)
   begin : g_lane
      assign dq[8*i +: 8] = dq_d_oe[i] ? dq_d2c[8*i +: 8] :
                            (dq_c_oe ? dq_c2d[8*i +: 8] : 8'h00);
   end

   modport ctrl (
      output cs_n, ras_n, cas_n, we_n, cke, bank_select_lo, bank_select_hi,
      output addr, dqm, dq_c2d, dq_c_oe,
      input dq_d2c, dq_d_oe, dq
   );
   modport dev (
      input cs_n, ras_n, cas_n, we_n, cke, bank_select_lo, bank_select_hi,
      input addr, dqm, dq_c2d, dq_c_oe, dq,
      output dq_d2c, dq_d_oe
   );
endinterface : sdram_link_if
`default_nettype wire
